// ---- rtl/rcw_pkg.sv ----
// Package of constants and types for the channel reconfiguration word writer.
`default_nettype none
package rcw_pkg;

  // ----------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------
  localparam int ADDR_W        = 6;   // Word address counter width.
  localparam int DATA_W        = 16;  // Reconfiguration word width.
  localparam int LAST_ADDR_DEF = 63;  // Default last word address.
  localparam int OC_CYCLES     = 16;  // Offset cancellation run length.
  localparam int WORD_CYCLES   = 16;  // Cycles to write one word.
  localparam int REG_AW        = 4;   // Register bus byte address width.
  localparam int INT_W         = 3;   // Number of interrupt events.

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [REG_AW-1:0] REG_CTRL     = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS   = 4'h4;
  localparam logic [REG_AW-1:0] REG_INT_STAT = 4'h8;
  localparam logic [REG_AW-1:0] REG_INT_MASK = 4'hc;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_WR_EN_BIT  = 0;  // Allows write requests.
  localparam int CTRL_ADR_CLR_BIT = 1; // Write one to clear the address.
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_OC_BIT     = 2;
  localparam int STAT_MODE_LSB   = 4;
  localparam int STAT_ADDR_LSB   = 8;
  localparam int INT_WORD_BIT    = 0;  // One word written.
  localparam int INT_SEQ_BIT     = 1;  // Whole sequence written.
  localparam int INT_REFUSE_BIT  = 2;  // Request refused.

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic       CTRL_WR_EN_RST = 1'h1;
  localparam logic [2:0] INT_MASK_RST   = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RCW_MODE_ANALOG  = 3'b000,
    RCW_MODE_CHANNEL = 3'b001
  } rcw_mode_e;

  typedef enum logic [1:0] {
    RCW_ST_IDLE  = 2'b00,
    RCW_ST_OCAN  = 2'b01,
    RCW_ST_WRITE = 2'b10
  } rcw_state_e;

endpackage : rcw_pkg

`default_nettype wire

// ---- rtl/rcw_writer.sv ----
// Channel reconfiguration word writer with register port and interrupt.
//
// Contract
// - Mode code 000 is analog, the default.
// - Mode code 001 selects channel reconfiguration.
// - Mode select used only with several modes.
// - Address shows word, steps by one, wraps.
// - Wrap to zero marks all words written.
// - Address strobe pulses after each whole word.
// - Reset returns all registers, aborts writing; reset_i keeps oc_done, only por_i clears it.
// - Reset input serves channel reconfiguration build.
// - Done flag rises after all words.
// - Done clears itself when sequence restarts.
// - Outputs meaningful only in channel mode.
// - Reset does not rerun offset cancellation.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module rcw_writer #(
  parameter int                      LAST_ADDR   = rcw_pkg::LAST_ADDR_DEF, // Last word address.
  parameter int                      WORD_CYCLES = rcw_pkg::WORD_CYCLES,   // Cycles per word.
  parameter int                      OC_CYCLES   = rcw_pkg::OC_CYCLES,     // Offset cancel length.
  parameter bit                      MULTI_MODE  = 1'b1,                   // Several modes built.
  parameter rcw_pkg::rcw_mode_e      FIXED_MODE  = rcw_pkg::RCW_MODE_CHANNEL // Mode if only one.
) (
  input  wire logic                        clk_sys_i,    // System clock, 20 MHz.
  input  wire logic                        reset_i,      // Controller reset, synchronous.
  input  wire logic                        por_i,        // Power-on reset, synchronous.
  input  wire logic [2:0]                  mode_sel_i,   // Mode select code.
  input  wire logic                        write_all_i,  // Word write request.
  input  wire logic [rcw_pkg::DATA_W-1:0]  data_i,       // Word to write.
  input  wire logic                        addr_clear_i, // Address counter clear.
  output logic      [rcw_pkg::ADDR_W-1:0]  addr_o,       // Current word address.
  output logic                             addr_en_o,    // Address changed strobe.
  output logic                             done_o,       // All words written.
  output logic                             busy_o,       // Controller busy.
  output logic                             chan_we_o,    // Word start to the channel.
  output logic      [rcw_pkg::ADDR_W-1:0]  chan_addr_o,  // Word address to the channel.
  output logic      [rcw_pkg::DATA_W-1:0]  chan_data_o,  // Word data to the channel.
  input  wire logic [rcw_pkg::REG_AW-1:0]  reg_addr_i,   // Register byte address.
  input  wire logic [31:0]                 reg_wdata_i,  // Register write data.
  input  wire logic                        reg_we_i,     // Register write strobe.
  input  wire logic                        reg_re_i,     // Register read strobe.
  output logic      [31:0]                 reg_rdata_o,  // Register read data.
  output logic                             irq_o         // Interrupt, active high level.
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------

  // The address counter is six bits, so the last address must fit it.
  if (LAST_ADDR < 0 || LAST_ADDR > (1 << rcw_pkg::ADDR_W) - 1) begin : g_chk_last
    $error("LAST_ADDR does not fit the address counter.");
  end
  // Both run lengths need at least one cycle and must fit the counter.
  if (WORD_CYCLES < 1 || OC_CYCLES < 1 || WORD_CYCLES > 255 || OC_CYCLES > 255) begin : g_chk_cyc
    $error("Cycle counts must lie between 1 and 255.");
  end

  // ----------------------------------------------------------------------
  // Constants and declarations
  // ----------------------------------------------------------------------

  localparam int                     CNT_W    = 8;                           // Run counter width.
  localparam logic [rcw_pkg::ADDR_W-1:0] ADDR_LAST = rcw_pkg::ADDR_W'(LAST_ADDR); // Last address.
  localparam logic [CNT_W-1:0]       WORD_END = CNT_W'(WORD_CYCLES - 1);     // Last word cycle.
  localparam logic [CNT_W-1:0]       OC_END   = CNT_W'(OC_CYCLES - 1);       // Last cancel cycle.

  rcw_pkg::rcw_state_e             state;        // Controller state.
  rcw_pkg::rcw_state_e             next_state;   // Next controller state.
  rcw_pkg::rcw_mode_e              mode;         // Effective mode.
  logic [CNT_W-1:0]                cnt;          // Cycle counter of a run.
  logic                            oc_done;      // Offset cancellation finished.
  logic                            wr_en;        // Software write enable.
  logic [rcw_pkg::INT_W-1:0]       int_stat;     // Sticky event bits.
  logic [rcw_pkg::INT_W-1:0]       int_mask;     // Event mask.
  logic                            is_chan;      // Channel mode active.
  logic                            accept;       // Request taken this cycle.
  logic                            refuse;       // Request refused this cycle.
  logic                            word_end;     // Word write completes.
  logic                            oc_end;       // Offset cancellation completes.
  logic                            clr_addr;     // Address clear from any source.
  logic                            wr_ctrl;      // Write to the control register.
  logic [rcw_pkg::INT_W-1:0]       events;       // Events of this cycle.
  logic [31:0]                     rd_mux;       // Read data selection.

  // Advances a word address and wraps after the last one.
  function automatic logic [rcw_pkg::ADDR_W-1:0] step_addr(input logic [rcw_pkg::ADDR_W-1:0] a);
    if (a == ADDR_LAST) begin
      return '0;
    end
    return a + rcw_pkg::ADDR_W'(1);
  endfunction

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------

  // Picks the mode from the select input or the fixed build choice.
  always_comb begin
    if (MULTI_MODE) begin
      mode = rcw_pkg::rcw_mode_e'(mode_sel_i);
    end else begin
      mode = FIXED_MODE;
    end
    unique case (mode)
      rcw_pkg::RCW_MODE_ANALOG: begin
        is_chan = 1'b0;
      end
      rcw_pkg::RCW_MODE_CHANNEL: begin
        is_chan = 1'b1;
      end
      default: begin
        // Undefined codes start no word writes.
        is_chan = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------

  // Derives the request, completion and clear conditions of the cycle.
  always_comb begin
    wr_ctrl  = reg_we_i && (reg_addr_i == rcw_pkg::REG_CTRL);
    // Only an idle controller in channel mode takes a word.
    accept   = (state == rcw_pkg::RCW_ST_IDLE) && write_all_i && is_chan && wr_en;
    refuse   = write_all_i && !accept;
    word_end = (state == rcw_pkg::RCW_ST_WRITE) && (cnt == WORD_END);
    oc_end   = (state == rcw_pkg::RCW_ST_OCAN) && (cnt == OC_END);
    clr_addr = addr_clear_i || (wr_ctrl && reg_wdata_i[rcw_pkg::CTRL_ADR_CLR_BIT]);
    events   = '0;
    events[rcw_pkg::INT_WORD_BIT]   = word_end;
    events[rcw_pkg::INT_SEQ_BIT]    = word_end && (addr_o == ADDR_LAST);
    events[rcw_pkg::INT_REFUSE_BIT] = refuse;
  end

  // ----------------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------------

  // Chooses the next state of the controller.
  always_comb begin
    next_state = state;
    unique case (state)
      rcw_pkg::RCW_ST_IDLE: begin
        if (accept) begin
          next_state = rcw_pkg::RCW_ST_WRITE;
        end
      end
      rcw_pkg::RCW_ST_OCAN: begin
        if (oc_end) begin
          next_state = rcw_pkg::RCW_ST_IDLE;
        end
      end
      rcw_pkg::RCW_ST_WRITE: begin
        if (word_end) begin
          next_state = rcw_pkg::RCW_ST_IDLE;
        end
      end
      default: begin
        // A lost code falls back to idle.
        next_state = rcw_pkg::RCW_ST_IDLE;
      end
    endcase
  end

  // Holds the state; after reset it reruns cancellation only if unfinished.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      state <= rcw_pkg::RCW_ST_OCAN;
    end else if (state == rcw_pkg::RCW_ST_OCAN && oc_done) begin
      state <= rcw_pkg::RCW_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counts the cycles of a word write or of offset cancellation.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      cnt <= '0;
    end else if (accept || next_state == rcw_pkg::RCW_ST_IDLE) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // Remembers finished cancellation; the controller reset leaves it alone.
  always_ff @(posedge clk_sys_i) begin
    if (por_i) begin
      oc_done <= 1'b0;
    end else if (oc_end && !reset_i) begin
      oc_done <= 1'b1;
    end
  end

  // Shows busy while cancelling or writing.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      busy_o <= 1'b1;
    end else if (state == rcw_pkg::RCW_ST_OCAN && oc_done) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (next_state != rcw_pkg::RCW_ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Word address and completion
  // ----------------------------------------------------------------------

  // Steps the address after each word and pulses the strobe with it.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      addr_o    <= '0;
      addr_en_o <= 1'b0;
    end else if (word_end) begin
      // A clear in the same cycle still ends on zero.
      addr_o    <= clr_addr ? '0 : step_addr(addr_o);
      addr_en_o <= 1'b1;
    end else begin
      if (clr_addr) begin
        addr_o <= '0;
      end
      addr_en_o <= 1'b0;
    end
  end

  // Raises done after the last word; a restart at address zero drops it.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      done_o <= 1'b0;
    end else if (word_end && addr_o == ADDR_LAST) begin
      done_o <= 1'b1;
    end else if (accept && addr_o == '0) begin
      done_o <= 1'b0;
    end
  end

  // Hands the word and its address to the channel as a request is taken.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      chan_we_o   <= 1'b0;
      chan_addr_o <= '0;
      chan_data_o <= '0;
    end else begin
      chan_we_o <= accept;
      if (accept) begin
        chan_addr_o <= addr_o;
        chan_data_o <= data_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------

  // Holds the software write enable.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      wr_en <= rcw_pkg::CTRL_WR_EN_RST;
    end else if (wr_ctrl) begin
      wr_en <= reg_wdata_i[rcw_pkg::CTRL_WR_EN_BIT];
    end
  end

  // Holds the interrupt mask.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      int_mask <= rcw_pkg::INT_MASK_RST;
    end else if (reg_we_i && reg_addr_i == rcw_pkg::REG_INT_MASK) begin
      int_mask <= reg_wdata_i[rcw_pkg::INT_W-1:0];
    end
  end

  // Sets sticky bits on events; a write of one clears, but a new event wins.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      int_stat <= '0;
    end else if (reg_we_i && reg_addr_i == rcw_pkg::REG_INT_STAT) begin
      int_stat <= (int_stat & ~reg_wdata_i[rcw_pkg::INT_W-1:0]) | events;
    end else begin
      int_stat <= int_stat | events;
    end
  end

  // Drives the interrupt while any unmasked sticky bit is set.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_stat & int_mask);
    end
  end

  // Selects read data; unmapped offsets read as zero.
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      rcw_pkg::REG_CTRL: begin
        rd_mux[rcw_pkg::CTRL_WR_EN_BIT] = wr_en;
      end
      rcw_pkg::REG_STATUS: begin
        rd_mux[rcw_pkg::STAT_BUSY_BIT] = busy_o;
        rd_mux[rcw_pkg::STAT_DONE_BIT] = done_o;
        rd_mux[rcw_pkg::STAT_OC_BIT]   = oc_done;
        rd_mux[rcw_pkg::STAT_MODE_LSB +: 3] = mode;
        rd_mux[rcw_pkg::STAT_ADDR_LSB +: rcw_pkg::ADDR_W] = addr_o;
      end
      rcw_pkg::REG_INT_STAT: begin
        rd_mux[rcw_pkg::INT_W-1:0] = int_stat;
      end
      rcw_pkg::REG_INT_MASK: begin
        rd_mux[rcw_pkg::INT_W-1:0] = int_mask;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Presents read data in the cycle after the strobe only.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || por_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : rcw_writer

`default_nettype wire

// ---- verif/rcw_user_model.sv ----
// Model of the user logic that feeds reconfiguration words.
`timescale 1ns/1ps
`default_nettype none

module rcw_user_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        go_i,        // One request wanted.
  input  wire logic        rude_i,      // Push without waiting for idle.
  input  wire logic [3:0]  gap_i,       // Idle cycles before pushing.
  input  wire logic [15:0] word_i,      // Word to hand over.
  input  wire logic        busy_i,      // Writer busy.
  output logic             write_all_o, // Request, one cycle.
  output logic      [15:0] data_o       // Word beside the request.
);
  logic       pend;     // A request waits to go out.
  logic [3:0] wait_cnt; // Remaining idle cycles.

  // Issues one request per go, then lets the data line wander.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pend        <= 1'b0;
      wait_cnt    <= 4'h0;
      write_all_o <= 1'b0;
      data_o      <= 16'h0000;
    end else if (go_i) begin
      // A request already out ends here, so it stays one cycle long.
      write_all_o <= 1'b0;
      pend     <= 1'b1;
      wait_cnt <= gap_i;
    end else if (pend && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (pend && (!busy_i || rude_i)) begin
      write_all_o <= 1'b1;
      data_o      <= word_i;
      pend        <= 1'b0;
    end else begin
      write_all_o <= 1'b0;
      data_o      <= ~data_o; // Released data is not held.
    end
  end
endmodule // rcw_user_model

`default_nettype wire

// ---- verif/rcw_writer_sva.sv ----
// Assertion checker bound to the channel reconfiguration word writer.
`timescale 1ns/1ps
`default_nettype none

module rcw_writer_sva #(
  parameter int LAST_ADDR   = 63, // Last word address.
  parameter int WORD_CYCLES = 16  // Cycles to write one word.
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        por_i,
  input wire logic [2:0]  mode_sel_i,
  input wire logic        write_all_i,
  input wire logic [15:0] data_i,
  input wire logic        addr_clear_i,
  input wire logic [5:0]  addr_o,
  input wire logic        addr_en_o,
  input wire logic        done_o,
  input wire logic        busy_o,
  input wire logic        chan_we_o,
  input wire logic [5:0]  chan_addr_o,
  input wire logic [15:0] chan_data_o,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_we_i
);
  logic [7:0] word_cnt; // Cycles since the last word start.
  logic       clr_q;    // A clear or reset was seen one edge back.

  // Counts word time so the strobe can be tied to its word start.
  always_ff @(posedge clk_sys_i) begin
    // The control register's clear bit also zeroes the address.
    clr_q <= reset_i | por_i | addr_clear_i | (reg_we_i & (reg_addr_i == 4'h0) & reg_wdata_i[1]);
    if (reset_i || por_i) begin
      word_cnt <= 8'h00;
    end else if (chan_we_o) begin
      word_cnt <= 8'h01;
    end else if (word_cnt != 8'hff) begin
      word_cnt <= word_cnt + 8'h01;
    end
  end

  a_strobe_after_word : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) addr_en_o |-> word_cnt == 8'(WORD_CYCLES))
    else $error("address strobe not one word time after word start");
  a_strobe_single_cycle : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) addr_en_o |=> !addr_en_o)
    else $error("address strobe longer than one cycle");
  a_addr_step_one : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) addr_en_o && !clr_q |->
      addr_o == (($past(addr_o) == 6'(LAST_ADDR)) ? 6'h00 : $past(addr_o) + 6'h01))
    else $error("address did not step by one or wrap");
  a_addr_moves_strobed : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) $changed(addr_o) |-> addr_en_o || clr_q)
    else $error("address changed without strobe");
  a_done_on_wrap : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) addr_en_o && addr_o == 6'h00 && !clr_q |-> done_o)
    else $error("done not raised on wrap");
  a_done_restart_clear : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) chan_we_o && chan_addr_o == 6'h00 |-> !done_o)
    else $error("done still high at new sequence");
  a_busy_refuses : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) write_all_i && busy_o |=> !chan_we_o)
    else $error("request taken while busy");
  a_take_cause : assert property (
    @(posedge clk_sys_i) disable iff (reset_i || por_i) chan_we_o |-> $past(write_all_i) && !$past(busy_o)
      && $past(mode_sel_i) == 3'b001 && chan_data_o == $past(data_i))
    else $error("word start without valid channel request");
  a_reset_clears : assert property (
    @(posedge clk_sys_i) disable iff (por_i) reset_i |=> busy_o && !done_o && !addr_en_o && addr_o == 6'h00)
    else $error("reset did not return outputs");
endmodule // rcw_writer_sva

bind rcw_writer rcw_writer_sva #(.LAST_ADDR(LAST_ADDR), .WORD_CYCLES(WORD_CYCLES)) rcw_writer_sva_inst (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .por_i(por_i), .mode_sel_i(mode_sel_i),
  .write_all_i(write_all_i), .data_i(data_i), .addr_clear_i(addr_clear_i), .addr_o(addr_o),
  .addr_en_o(addr_en_o), .done_o(done_o), .busy_o(busy_o), .chan_we_o(chan_we_o),
  .chan_addr_o(chan_addr_o), .chan_data_o(chan_data_o), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i));

`default_nettype wire

// ---- verif/rcw_writer_tb_top.sv ----
// Testbench top for the channel reconfiguration word writer.
`timescale 1ns/1ps
`default_nettype none

module rcw_writer_tb_top;
  localparam int LAST = 3; // Four words per sequence.
  logic        clk_sys_i, reset_i, por_i, addr_clear_i, go, rude, write_all_i;
  logic        reg_we_i, reg_re_i, addr_en_o, done_o, busy_o, chan_we_o, irq_o;
  logic [2:0]  mode_sel_i;
  logic [3:0]  gap, reg_addr_i;
  logic [5:0]  addr_o, chan_addr_o;
  logic [15:0] word_w, data_i, chan_data_o;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  int          num_errors, samples_checked;

  rcw_writer #(.LAST_ADDR(LAST), .WORD_CYCLES(4), .OC_CYCLES(8)) rcw_writer_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .por_i(por_i), .mode_sel_i(mode_sel_i),
    .write_all_i(write_all_i), .data_i(data_i), .addr_clear_i(addr_clear_i), .addr_o(addr_o),
    .addr_en_o(addr_en_o), .done_o(done_o), .busy_o(busy_o), .chan_we_o(chan_we_o),
    .chan_addr_o(chan_addr_o), .chan_data_o(chan_data_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o));

  rcw_user_model rcw_user_model_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .go_i(go), .rude_i(rude), .gap_i(gap), .word_i(word_w),
    .busy_i(busy_o), .write_all_o(write_all_i), .data_o(data_i));

  // Clock of 50 ns period.
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Compares and counts one value.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Register write and read, one strobe cycle each.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b0;
    @(negedge clk_sys_i);
    check(reg_rdata_o, exp);
  endtask

  // Asks the user model for one request.
  task automatic send(input logic [15:0] w, input logic r, input logic [3:0] g);
    @(posedge clk_sys_i);
    word_w <= w;
    rude   <= r;
    gap    <= g;
    go     <= 1'b1;
    @(posedge clk_sys_i);
    go     <= 1'b0;
  endtask

  // One whole word: start at address a, strobe with the next address.
  task automatic word(input logic [15:0] w, input logic [5:0] a, input logic [3:0] g);
    send(w, 1'b0, g);
    for (int i = 0; i < 30 && chan_we_o !== 1'b1; i++) @(negedge clk_sys_i);
    check({chan_addr_o, chan_data_o}, {a, w});
    for (int i = 0; i < 30 && addr_en_o !== 1'b1; i++) @(negedge clk_sys_i);
    check({addr_en_o, addr_o}, {1'b1, (a == 6'(LAST)) ? 6'h00 : a + 6'h01});
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    num_errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    {reset_i, por_i} = 2'b11;
    {addr_clear_i, go, rude, reg_we_i, reg_re_i} = 5'h00;
    mode_sel_i = 3'b000;
    {gap, reg_addr_i, word_w, reg_wdata_i} = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    por_i   <= 1'b0;
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) @(negedge clk_sys_i);
    rd(rcw_pkg::REG_CTRL, 32'h1);
    rd(rcw_pkg::REG_INT_MASK, 32'h0);
    wr(4'h2, 32'hffffffff);
    rd(4'h2, 32'h0);
    rd(rcw_pkg::REG_STATUS, 32'h4);
    // Default mode must refuse words and flag an interrupt.
    send(16'h1234, 1'b0, 4'h0);
    repeat (8) @(negedge clk_sys_i);
    check(addr_o, 6'h00);
    rd(rcw_pkg::REG_INT_STAT, 32'h4);
    wr(rcw_pkg::REG_INT_MASK, 32'h4);
    repeat (2) @(negedge clk_sys_i);
    check(irq_o, 1'b1);
    wr(rcw_pkg::REG_INT_STAT, 32'h4);
    repeat (2) @(negedge clk_sys_i);
    check(irq_o, 1'b0);
    // Channel mode: a full sequence, some words slow.
    @(posedge clk_sys_i);
    mode_sel_i <= rcw_pkg::RCW_MODE_CHANNEL;
    for (int k = 0; k <= LAST; k++) word(16'ha500 + 16'(k), 6'(k), 4'(k));
    check({done_o, addr_o}, 7'h40);
    rd(rcw_pkg::REG_INT_STAT, 32'h3);
    wr(rcw_pkg::REG_INT_STAT, 32'h7);
    word(16'hbeef, 6'h00, 4'h0);
    check(done_o, 1'b0);
    // A second push while busy is dropped.
    send(16'h5555, 1'b0, 4'h0);
    send(16'h6666, 1'b1, 4'h0);
    repeat (12) @(negedge clk_sys_i);
    check(addr_o, 6'h02);
    rd(rcw_pkg::REG_INT_STAT, 32'h5);
    // Address clear held for one cycle.
    @(posedge clk_sys_i);
    addr_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    addr_clear_i <= 1'b0;
    @(negedge clk_sys_i);
    check(addr_o, 6'h00);
    // Register clear bit zeroes the address; write enable off refuses words.
    word(16'h9999, 6'h00, 4'h0);
    wr(rcw_pkg::REG_INT_STAT, 32'h7);
    wr(rcw_pkg::REG_CTRL, 32'h2);
    send(16'h8888, 1'b0, 4'h0);
    repeat (8) @(negedge clk_sys_i);
    check(addr_o, 6'h00);
    rd(rcw_pkg::REG_INT_STAT, 32'h4);
    wr(rcw_pkg::REG_CTRL, 32'h1);
    // Reset in mid word aborts it; cancellation does not rerun.
    send(16'h7777, 1'b0, 4'h0);
    for (int i = 0; i < 30 && chan_we_o !== 1'b1; i++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    check({busy_o, done_o, addr_o}, 8'h80);
    for (int i = 0; i < 3 && busy_o !== 1'b0; i++) @(negedge clk_sys_i);
    check(busy_o, 1'b0);
    rd(rcw_pkg::REG_STATUS, 32'h14);
    summarize();
  end
endmodule // rcw_writer_tb_top

`default_nettype wire
